// file: logic/timer16_pkg.sv
// Constants, register map and field layout of the 16-bit timer/event counter.
// Assumes a 32-bit APB slave port with byte addresses, one word per register.
package timer16_pkg;

    localparam int          ADDR_W       = 8;
    localparam int          CNT_W        = 16;
    localparam int          PRE_W        = 8;

    // Register byte offsets
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  TRIG_OFS     = 8'h04;
    localparam logic [7:0]  CCA_OFS      = 8'h08;
    localparam logic [7:0]  CCB_OFS      = 8'h0c;
    localparam logic [7:0]  COUNT_OFS    = 8'h10;
    localparam logic [7:0]  IRQ_STAT_OFS = 8'h14;
    localparam logic [7:0]  IRQ_CLR_OFS  = 8'h18;
    localparam logic [7:0]  IRQ_EN_OFS   = 8'h1c;

    // Control and trigger register fields
    localparam int          MODE_LSB     = 0;
    localparam int          CAP_SRC_BIT  = 2;
    localparam int          EDGE_A_LSB   = 3;
    localparam int          EDGE_B_LSB   = 5;
    localparam int          CAP_A_BIT    = 7;
    localparam int          CAP_B_BIT    = 8;
    localparam int          OUT_EN_BIT   = 9;
    localparam int          PPG_BIT      = 10;
    localparam int          ONESHOT_BIT  = 11;
    localparam int          EXT_EV_BIT   = 12;
    localparam int          CLK_SEL_LSB  = 13;
    localparam int          CTRL_W       = 16;
    localparam int          OSPT_BIT     = 0;

    // Interrupt status bits
    localparam int          IRQ_A_BIT    = 0;
    localparam int          IRQ_B_BIT    = 1;
    localparam int          IRQ_OVF_BIT  = 2;
    localparam int          IRQ_W        = 3;

    // Reset values and event-counting arm edge count
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] CC_RST       = 16'hffff;
    localparam logic [2:0]  IRQ_EN_RST   = 3'h0;
    localparam logic [1:0]  EV_ARM_EDGES = 2'h2;

    typedef enum logic [1:0] {
        MODE_STOP      = 2'b00,
        MODE_CLR_EDGE  = 2'b01,
        MODE_FREE      = 2'b10,
        MODE_CLR_MATCH = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_NONE = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_sel_t;

endpackage : timer16_pkg

// file: logic/timer16.sv
// 16-bit timer/event counter with two capture/compare registers behind APB.
// Assumes edge inputs already synchronous to sys_clk; one clock domain.
`timescale 1ns/1ps

// Overview of operation
// [R1] Nonzero mode code starts counting at once
// [R2] Start unaligned to count tick, one-tick error
// [R3] One-shot only in free-run or edge-clear modes
// [R4] Source select 1, both edges: no capture; the code still captures into register b
// [R5] Source select 1: input b only interrupts
// [R6] Software avoids compare rewrites near a match
// [R7] Unsynchronised compare b rewrite may toggle output
// [R8] Event counting starts after two valid edges
// [R9] Software never loads zero in pulse modes
// [R10] Pulse period a+1, duty (b+1)/(a+1)
// [R11] Software waits before retriggering a one-shot
// [R12] External trigger stays live in software one-shot
// [R13] Match with register a pulses interrupt a
module timer16
    import timer16_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic [ADDR_W-1:0]   paddr,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                edge_input_a,
    input  wire logic                edge_input_b,
    output logic                     timer_output_pin,
    output logic                     match_capture_irq_a,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [CNT_W-1:0]  sixteenBitCounter;
        logic [CNT_W-1:0]  captureCompareRegA;
        logic [CNT_W-1:0]  captureCompareRegB;
        logic [IRQ_W-1:0]  irqStat;
        logic [IRQ_W-1:0]  irqEn;
        logic [PRE_W-1:0]  pre;
        logic              prevA;
        logic              prevB;
        logic [1:0]        evArm;
        logic              osArmed;
        logic              outLevel;
        logic              irqAPulse;
        logic              irqLine;
        logic              ready;
        logic              slvErr;
        logic [31:0]       rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic edgeValid(input logic prev, input logic cur,
                                       input logic [1:0] sel);
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        case (edge_sel_t'(sel))
            EDGE_FALL: edgeValid = fall;
            EDGE_RISE: edgeValid = rise;
            EDGE_BOTH: edgeValid = rise | fall;
            default:   edgeValid = 1'b0;
        endcase
    endfunction : edgeValid

    function automatic logic [PRE_W-1:0] divMask(input logic [2:0] sel);
        divMask = PRE_W'((9'h001 << sel) - 9'h001);
    endfunction : divMask

    ////////////////////////////////////////////////////////////////////////////
    // Decoded controls

    mode_t      mode;
    logic       running;
    logic       capSrc;
    logic [1:0] edgeASel;
    logic       capModeA;
    logic       capModeB;
    logic       outEn;
    logic       ppgEn;
    logic       oneshotEn;
    logic       extEvent;
    logic [2:0] clkSel;

    always_comb begin
        mode      = mode_t'(state_reg.ctrl[MODE_LSB +: 2]);
        running   = (mode != MODE_STOP);
        capSrc    = state_reg.ctrl[CAP_SRC_BIT];
        edgeASel  = state_reg.ctrl[EDGE_A_LSB +: 2];
        capModeA  = state_reg.ctrl[CAP_A_BIT];
        capModeB  = state_reg.ctrl[CAP_B_BIT];
        outEn     = state_reg.ctrl[OUT_EN_BIT];
        ppgEn     = state_reg.ctrl[PPG_BIT];
        oneshotEn = state_reg.ctrl[ONESHOT_BIT];
        extEvent  = state_reg.ctrl[EXT_EV_BIT];
        clkSel    = state_reg.ctrl[CLK_SEL_LSB +: 3];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic       setup;
    logic       wrAcc;
    logic       mapped;
    logic       validA;
    logic       validB;
    logic       tick;
    logic       presTick;
    logic       evTick;
    logic       matchA;
    logic       matchB;
    logic       overflow;
    logic       osAllowed;
    logic       trig;
    logic       capAEvt;
    logic       capBEvt;
    logic       irqAEvt;
    logic       irqBEvt;
    logic       reapplyB;
    logic [2:0] irqClr;
    logic [2:0] irqSet;

    always_comb begin
        state_next = state_reg;

        setup  = psel & ~penable;
        wrAcc  = psel & penable & state_reg.ready & pwrite;
        mapped = (paddr == CTRL_OFS) || (paddr == TRIG_OFS) || (paddr == CCA_OFS)
              || (paddr == CCB_OFS) || (paddr == COUNT_OFS) || (paddr == IRQ_STAT_OFS)
              || (paddr == IRQ_CLR_OFS) || (paddr == IRQ_EN_OFS);

        validA = edgeValid(state_reg.prevA, edge_input_a, edgeASel);
        validB = edgeValid(state_reg.prevB, edge_input_b, state_reg.ctrl[EDGE_B_LSB +: 2]);
        state_next.prevA = edge_input_a;
        state_next.prevB = edge_input_b;

        // Prescaler runs free, so a start lands anywhere in a tick period
        state_next.pre = state_reg.pre + 8'h01; // see [R2]
        presTick = ((state_reg.pre & divMask(clkSel)) == divMask(clkSel));

        // Event counting: the first two valid edges only arm the counter
        evTick = 1'b0;
        if (!running) begin
            state_next.evArm = 2'h0;
        end else if (extEvent && validA) begin
            if (state_reg.evArm != EV_ARM_EDGES) begin // see [R8]
                state_next.evArm = state_reg.evArm + 2'h1;
            end else begin
                evTick = 1'b1; // see [R8]
            end
        end

        tick = running & (extEvent ? evTick : presTick); // see [R1]

        matchA = tick & ~capModeA
               & (state_reg.sixteenBitCounter == state_reg.captureCompareRegA);
        matchB = tick & ~capModeB
               & (state_reg.sixteenBitCounter == state_reg.captureCompareRegB);
        overflow = tick & (mode != MODE_CLR_MATCH)
                 & (state_reg.sixteenBitCounter == 16'hffff);

        // Match-clear mode never overflows, so it cannot run a one-shot
        osAllowed = oneshotEn & ((mode == MODE_FREE) | (mode == MODE_CLR_EDGE)); // see [R3]
        // The pin trigger stays live next to the software trigger
        trig = osAllowed & ((wrAcc & (paddr == TRIG_OFS) & pwdata[OSPT_BIT])
                            | (validA & ~extEvent)); // see [R12]

        // Counter
        if (!running) begin
            state_next.sixteenBitCounter = '0;
        end else if (trig || (mode == MODE_CLR_EDGE && validA && !extEvent)) begin
            state_next.sixteenBitCounter = '0; // see [R12]
        end else if (tick) begin
            if (mode == MODE_CLR_MATCH
                && state_reg.sixteenBitCounter == state_reg.captureCompareRegA) begin
                state_next.sixteenBitCounter = '0;
            end else begin
                state_next.sixteenBitCounter = state_reg.sixteenBitCounter + 16'h0001;
            end
        end

        // Capture; source select 1 with both edges on input a blocks capture into register a
        capAEvt = running & capModeA
                & (capSrc ? (validA & (edge_sel_t'(edgeASel) != EDGE_BOTH)) // see [R4]
                          : validB);
        capBEvt = running & capModeB & validA;
        if (capAEvt) begin
            state_next.captureCompareRegA = state_reg.sixteenBitCounter;
        end
        if (capBEvt) begin
            state_next.captureCompareRegB = state_reg.sixteenBitCounter;
        end

        // Input b still interrupts when it no longer captures
        irqAEvt = matchA | capAEvt | (running & capSrc & validB); // see [R5] [R13]
        irqBEvt = matchB | capBEvt;

        // Compare b takes a write at once; hitting the live count re-fires it
        reapplyB = wrAcc & (paddr == CCB_OFS) & running & ~capModeB
                 & (pwdata[15:0] == state_reg.sixteenBitCounter);

        // Timer output
        if (!outEn || !running) begin
            state_next.outLevel = 1'b0;
            state_next.osArmed  = 1'b0;
        end else if (ppgEn && mode == MODE_CLR_MATCH) begin
            // High for counts 0..b of each 0..a period
            state_next.outLevel = (state_reg.sixteenBitCounter
                                   <= state_reg.captureCompareRegB); // see [R10]
        end else if (osAllowed) begin
            if (trig) begin
                state_next.osArmed  = 1'b1;
                state_next.outLevel = 1'b0;
            end else if (state_reg.osArmed && matchB) begin
                state_next.outLevel = 1'b1;
            end else if (state_reg.osArmed && matchA) begin
                state_next.outLevel = 1'b0;
                state_next.osArmed  = 1'b0;
            end
        end else if (matchA ^ (matchB | reapplyB)) begin
            state_next.outLevel = ~state_reg.outLevel; // see [R7]
        end

        // Register writes
        irqClr = 3'h0;
        if (wrAcc) begin
            case (paddr)
                CTRL_OFS:    state_next.ctrl = pwdata[CTRL_W-1:0]; // see [R1]
                CCA_OFS: begin
                    if (!capAEvt) begin
                        state_next.captureCompareRegA = pwdata[15:0];
                    end
                end
                CCB_OFS: begin
                    if (!capBEvt) begin
                        state_next.captureCompareRegB = pwdata[15:0];
                    end
                end
                IRQ_CLR_OFS: irqClr = pwdata[IRQ_W-1:0];
                IRQ_EN_OFS:  state_next.irqEn = pwdata[IRQ_W-1:0];
                default:     ;
            endcase
        end

        // Sticky status; a new event beats a clear in the same cycle
        irqSet = '0;
        irqSet[IRQ_A_BIT]   = irqAEvt;
        irqSet[IRQ_B_BIT]   = irqBEvt;
        irqSet[IRQ_OVF_BIT] = overflow;
        state_next.irqStat   = (state_reg.irqStat & ~irqClr) | irqSet;
        state_next.irqLine   = |(state_next.irqStat & state_next.irqEn);
        state_next.irqAPulse = irqAEvt; // see [R13]

        // APB answer: zero wait states, data prepared in the setup cycle
        state_next.ready  = setup;
        state_next.slvErr = setup & ~mapped;
        if (setup) begin
            case (paddr)
                CTRL_OFS:     state_next.rdata = {16'h0000, state_reg.ctrl};
                CCA_OFS:      state_next.rdata = {16'h0000, state_reg.captureCompareRegA};
                CCB_OFS:      state_next.rdata = {16'h0000, state_reg.captureCompareRegB};
                COUNT_OFS:    state_next.rdata = {16'h0000, state_reg.sixteenBitCounter};
                IRQ_STAT_OFS: state_next.rdata = {29'h0, state_reg.irqStat};
                IRQ_EN_OFS:   state_next.rdata = {29'h0, state_reg.irqEn};
                default:      state_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg                    <= '0;
            state_reg.ctrl               <= CTRL_RST;
            state_reg.captureCompareRegA <= CC_RST;
            state_reg.captureCompareRegB <= CC_RST;
            state_reg.irqEn              <= IRQ_EN_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata              = state_reg.rdata;
    assign pready              = state_reg.ready;
    assign pslverr             = state_reg.slvErr;
    assign timer_output_pin    = state_reg.outLevel;
    assign match_capture_irq_a = state_reg.irqAPulse;
    assign irq                 = state_reg.irqLine;

endmodule : timer16

// file: bench/timer16_sva.sv
// Concurrent checks on the ports of the timer/event counter.
// Assumes binding to timer16; tracks control and compare writes from APB.
`timescale 1ns/1ps
module timer16_sva
    import timer16_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        edge_input_a,
    input wire logic        edge_input_b,
    input wire logic        timer_output_pin,
    input wire logic        match_capture_irq_a,
    input wire logic        irq
);
    logic [15:0] ctrlReg, ccaReg, ccbReg;
    logic [16:0] perCnt;
    logic [1:0]  riseN;
    logic        pinQ, wrDone, ppgOn;
    assign wrDone = psel && penable && pready && pwrite;
    assign ppgOn  = ctrlReg[PPG_BIT] && ctrlReg[OUT_EN_BIT] && ctrlReg[1:0] == MODE_CLR_MATCH
                    && ctrlReg[15:13] == 3'h0;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrlReg <= CTRL_RST;
            ccaReg  <= CC_RST;
            ccbReg  <= CC_RST;
            perCnt  <= 17'h0;
            riseN   <= 2'h0;
            pinQ    <= 1'b0;
        end else begin
            pinQ   <= timer_output_pin;
            perCnt <= (timer_output_pin && !pinQ) ? 17'h1 : perCnt + 17'h1;
            if (wrDone && paddr == CTRL_OFS) ctrlReg <= pwdata[15:0];
            if (wrDone && paddr == CCA_OFS) ccaReg <= pwdata[15:0];
            if (wrDone && paddr == CCB_OFS) ccbReg <= pwdata[15:0];
            // Any write restarts the count of full periods seen
            if (wrDone) riseN <= 2'h0;
            else if (timer_output_pin && !pinQ && riseN != 2'h2) riseN <= riseN + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_stopped;
        (ctrlReg[1:0] == MODE_STOP) [*2];
    endsequence
    sequence s_edge_b;
        ctrlReg[CAP_SRC_BIT] && ctrlReg[6:5] == EDGE_RISE && $rose(edge_input_b);
    endsequence
    a_pready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (pready && paddr > IRQ_EN_OFS |-> pslverr)
        else $error("unmapped access not refused");
    a_stop_quiet: assert property (s_stopped |-> !timer_output_pin)
        else $error("output high while stopped");
    a_irq_single: assert property (match_capture_irq_a |=> !match_capture_irq_a)
        else $error("match pulse longer than one cycle");
    a_src_b_irq: assert property (s_edge_b |-> ##[0:3] match_capture_irq_a)
        else $error("input b edge raised no interrupt");
    a_ppg_period: assert property (ppgOn && riseN == 2'h2 && $rose(timer_output_pin)
        |-> perCnt == {1'b0, ccaReg} + 17'h1)
        else $error("pulse period wrong");
    a_ppg_duty: assert property (ppgOn && riseN == 2'h2 && $fell(timer_output_pin)
        |-> perCnt == {1'b0, ccbReg} + 17'h1)
        else $error("pulse width wrong");
endmodule : timer16_sva

// file: bench/edge_source.sv
// Model of the external trigger, capture and event pins.
// Assumes pulse is called just after a rising edge of sys_clk.
`timescale 1ns/1ps
module edge_source (
    input  wire logic sys_clk,
    output logic      edge_input_a,
    output logic      edge_input_b
);
    initial begin
        edge_input_a = 1'b0;
        edge_input_b = 1'b0;
    end
    // Both levels held three clocks, so each counts as one clean edge
    task automatic pulse(input logic which);
        if (which) edge_input_b <= 1'b1;
        else edge_input_a <= 1'b1;
        repeat (3) @(posedge sys_clk);
        edge_input_a <= 1'b0;
        edge_input_b <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : pulse
endmodule : edge_source

// file: bench/sixteen_bit_timer_event_counter_test.sv
// Self-checking bench for the 16-bit timer/event counter.
// Assumes timer16, its package, the checker and the edge source model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module sixteen_bit_timer_event_counter_test;
    import timer16_pkg::*;
    typedef struct packed { logic [31:0] d; logic e; logic rd; } note_t;
    logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, p0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv, v;
    logic        edge_input_a, edge_input_b, timer_output_pin, match_capture_irq_a, irq;
    note_t       notes[$];
    note_t       n;
    int          fails = 0, nCompared = 0, irqCnt = 0, k, hi;
    integer      seed = 32'he8f1e29d;
    timer16 dut(.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .edge_input_a(edge_input_a), .edge_input_b(edge_input_b),
        .timer_output_pin(timer_output_pin), .match_capture_irq_a(match_capture_irq_a), .irq(irq));
    edge_source src(.sys_clk(sys_clk), .edge_input_a(edge_input_a), .edge_input_b(edge_input_b));
    always #12.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk) begin
        if (match_capture_irq_a === 1'b1) irqCnt++;
        if (pready === 1'b1 && notes.size() > 0) begin
            n = notes.pop_front();
            if (n.rd) `CHK("prdata", n.d, prdata)
            `CHK("pslverr", n.e, pslverr)
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic rd, input logic er);
        int t;
        notes.push_back('{e, er, rd});
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        t = 0;
        do begin @(posedge sys_clk); t++; end while (pready !== 1'b1 && t < 20);
        if (t == 20) fails++;
        v = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, e, 1'b1, 1'b0);
    endtask : rd
    task tally_and_finish;
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0; srst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h0; pwdata = 32'h0;
        repeat (5) @(posedge sys_clk);
        srst <= 1'b0;
        rd(CTRL_OFS, 32'h0); rd(CCA_OFS, 32'hffff); rd(CCB_OFS, 32'hffff);
        rd(IRQ_EN_OFS, 32'h0); rd(IRQ_STAT_OFS, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1, 1'b1);
        for (k = 0; k < 4; k++) begin
            rv = $random(seed);
            rv[0] = 1'b1;
            wr(CCB_OFS, rv);
            rd(CCB_OFS, {16'h0, rv[15:0]});
        end
        wr(IRQ_EN_OFS, 32'h1); wr(CCA_OFS, 32'hf); wr(CTRL_OFS, 32'h3);
        k = 0;
        while (match_capture_irq_a !== 1'b1 && k < 100) begin @(posedge sys_clk); k++; end
        `CHK("start delay", 1'b1, k >= 15 && k <= 18)
        repeat (2) @(posedge sys_clk);
        `CHK("irq", 1'b1, irq)
        rd(IRQ_STAT_OFS, 32'h1);
        wr(IRQ_EN_OFS, 32'h0); repeat (2) @(posedge sys_clk);
        `CHK("irq masked", 1'b0, irq)
        wr(IRQ_EN_OFS, 32'h1); repeat (2) @(posedge sys_clk);
        `CHK("irq unmasked", 1'b1, irq)
        wr(CTRL_OFS, 32'h0); wr(IRQ_CLR_OFS, 32'h7); repeat (2) @(posedge sys_clk);
        `CHK("irq cleared", 1'b0, irq)
        rd(IRQ_STAT_OFS, 32'h0);
        // Period 10, width 4: any 50-cycle window holds 20 high cycles
        wr(CCA_OFS, 32'h9); wr(CCB_OFS, 32'h3); wr(CTRL_OFS, 32'h603);
        k = 0;
        while (timer_output_pin !== 1'b1 && k < 50) begin @(posedge sys_clk); k++; end
        hi = 0;
        repeat (50) begin @(posedge sys_clk); if (timer_output_pin === 1'b1) hi++; end
        `CHK("ppg high", 32'h14, hi)
        wr(CTRL_OFS, 32'h0);
        // Register a as capture, so a blocked capture is visible in its value
        wr(CCA_OFS, 32'h1234); wr(CTRL_OFS, 32'hbe);
        // No software retrigger is ever issued while a pulse runs
        src.pulse(1'b0);
        rd(CCA_OFS, 32'h1234);
        k = irqCnt;
        src.pulse(1'b1);
        `CHK("b irq", k + 1, irqCnt)
        rd(CCA_OFS, 32'h1234);
        wr(CTRL_OFS, 32'h0); wr(CTRL_OFS, 32'h100a);
        repeat (5) src.pulse(1'b0);
        rd(COUNT_OFS, 32'h3);
        // Deliberate rewrite of compare b onto the live count, slow ticks
        wr(CTRL_OFS, 32'h0); wr(CTRL_OFS, 32'he202); repeat (200) @(posedge sys_clk);
        apb(1'b0, COUNT_OFS, 32'h0, 32'h0, 1'b0, 1'b0);
        p0 = timer_output_pin;
        wr(CCB_OFS, v); repeat (2) @(posedge sys_clk);
        `CHK("toggle", ~p0, timer_output_pin)
        tally_and_finish;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        tally_and_finish;
    end
endmodule : sixteen_bit_timer_event_counter_test
bind timer16 timer16_sva chk(.sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .edge_input_a(edge_input_a), .edge_input_b(edge_input_b),
    .timer_output_pin(timer_output_pin), .match_capture_irq_a(match_capture_irq_a), .irq(irq));
